/* File: hdl/fcs_pkg.sv */
package fcs_pkg;

    // register addresses as seen on the cpu port
    localparam logic [31:0] FCS_ADDR_SYS_CFG   = 32'h18000002;
    localparam logic [31:0] FCS_ADDR_PENDING   = 32'h18010002;
    localparam logic [31:0] FCS_ADDR_FAULT_ADR = 32'h18030000;
    localparam logic [31:0] FCS_ADDR_FAULT_LOG = 32'h18040002;

    // field positions of the configuration register
    localparam int FCS_CFG_CTRL_LSB = 8;
    localparam int FCS_CFG_CTRL_MSB = 15;

    // reset value of the software controls, expansion bus reset released
    localparam logic [7:0]  FCS_CFG_CTRL_RST = 8'h08;

    // bus hold limit, longest time rounded down
    localparam int          FCS_CLK_PERIOD_PS = 4000;
    localparam int          FCS_HOLD_LIMIT_NS = 16000;
    localparam int          FCS_HOLD_CYCLES_I = FCS_HOLD_LIMIT_NS * 1000 / FCS_CLK_PERIOD_PS;
    localparam logic [11:0] FCS_HOLD_CYCLES   = 12'(FCS_HOLD_CYCLES_I);

    // wait states on a slow dma controller read
    localparam logic [3:0]  FCS_SLOW_WAIT_RST = 4'h4;

    // cycles after reset release before straps are valid
    localparam logic [1:0]  FCS_STRAP_DELAY = 2'h2;

    // attributes of the memory access that is in flight
    typedef struct packed {
        logic       is_read;
        logic       proc_board;
        logic [2:0] io_master_code;
        logic       io_master_valid;
        logic [1:0] acc_type;
        logic [3:0] byte_parity_fail;
    } fcs_fault_attr_t;

    // fault cause log layout, bit 15 down to bit 0
    typedef struct packed {
        logic       io_master_code_invalid_n;
        logic [2:0] io_master_code;
        logic       processor_board_fault;
        logic [2:0] rsvd;
        logic       timeout;
        logic       fault_was_read;
        logic [1:0] acc_type_n;
        logic [3:0] byte_parity_fail_n;
    } fcs_fault_log_t;

    // software controls, upper half of the configuration register
    typedef struct packed {
        logic parity_irq_enable;
        logic parity_fault_inject;
        logic slow_dma_read_enable;
        logic expansion_terminal_count_enable;
        logic expansion_bus_reset_n;
        logic software_end_of_process;
        logic scsi_dir_to_memory;
        logic scsi_dma_init;
    } fcs_cfg_ctrl_t;

endpackage : fcs_pkg

/* File: hdl/fcs_fault_capture_and_system_config.sv */
// Summary of operation
// - long bus hold disengages master, flags timeout
// - fault log bits 10..8 read zero
// - log bit 11 marks processor board fault
// - log records three bit io master code
// - log bit 15 low means code valid
// - fault address latches every cycle when free
// - fault raises level five irq, freezes address
// - pending register read releases irq and capture
// - config low byte status, high byte controls
// - config bit 0 shows cpu board kind
// - config bits 2:1 show scsi byte pointer
// - config bit 3 low when keyswitch locked
// - config bit 4 one after power-up reset
// - config bit 7 low when fpu fitted
// - config bit 8 holds scsi dma reset
// - config bit 9 steers scsi dma direction
// - config bit 10 drives dma end of process
// - config bit 11 active low expansion reset
// - config bit 12 enables terminal count drive
// - config bit 14 forces bad memory parity
// - parity irq only when config bit 15 set
// - slow read bit inserts dma read waits
// - log bit 6 records read versus write
// - log bits 3..0 low per bad byte
`timescale 1ns/1ps

module fcs_fault_capture_and_system_config
    import fcs_pkg::*;
#(
    parameter logic [3:0] SLOW_WAIT_CYCLES = FCS_SLOW_WAIT_RST
)
(
    input  wire logic            mclk,
    input  wire logic            reset,
    // cpu register port
    input  wire logic [31:0]     reg_addr,
    input  wire logic [31:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [31:0]          reg_rdata,
    // memory controller side
    input  wire logic [31:0]     mem_addr,
    input  wire fcs_fault_attr_t mem_attr,
    input  wire logic            mbus_hold,
    input  wire logic            parity_err,
    output logic                 master_disengage,
    output logic                 bus_error_irq_n,
    // board straps and panel pins
    input  wire logic            cpu_board_kind,
    input  wire logic            keyswitch_locked_n,
    input  wire logic            fpu_present_n,
    input  wire logic            keyswitch_reset_cause,
    // scsi and dma side
    input  wire logic [1:0]      scsi_byte_pointer,
    input  wire logic            dma_ctrl_read,
    output logic                 dma_read_wait,
    output logic                 scsi_dma_init,
    output logic                 scsi_dir_to_memory,
    output logic                 software_end_of_process,
    output logic                 expansion_bus_reset_n,
    output logic                 expansion_terminal_count_enable,
    output logic                 slow_dma_read_enable,
    output logic                 parity_fault_inject,
    output logic                 parity_irq_enable
);

    logic [31:0]     reg_rdata_ff;
    logic [31:0]     fault_addr_ff;
    fcs_fault_log_t  fault_log_ff;
    fcs_fault_log_t  nxt_fault_log;
    fcs_cfg_ctrl_t   cfg_ctrl_ff;
    logic            held_ff;
    logic            irq_n_ff;
    logic [11:0]     hold_cnt_ff;
    logic            disengage_ff;
    logic [3:0]      pin_meta_ff;
    logic [3:0]      pin_sync_ff;
    logic [1:0]      strap_cnt_ff;
    logic            cold_start_ff;
    logic [3:0]      wait_cnt_ff;
    logic            wait_ff;
    logic [15:0]     cfg_view;
    logic            timeout_evt;
    logic            parity_evt;
    logic            fault_evt;
    logic            release_evt;
    logic            capture;
    logic [31:0]     nxt_rdata;
    logic [3:0]      pin_raw;

    // two flip-flop synchroniser for the board pins
    assign pin_raw = {keyswitch_reset_cause, fpu_present_n, keyswitch_locked_n, cpu_board_kind};

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
        end
        else
        begin
            pin_meta_ff <= pin_raw;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // cold start caught once straps settle
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            strap_cnt_ff  <= 2'h0;
            cold_start_ff <= 1'b0;
        end
        else if (strap_cnt_ff != FCS_STRAP_DELAY + 2'h1)
        begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            // only the second synchroniser stage is read
            if (strap_cnt_ff == FCS_STRAP_DELAY)
            begin
                cold_start_ff <= ~pin_sync_ff[3];
            end
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            hold_cnt_ff <= 12'h000;
        end
        else if (!mbus_hold)
        begin
            hold_cnt_ff <= 12'h000;
        end
        else if (hold_cnt_ff != FCS_HOLD_CYCLES)
        begin
            hold_cnt_ff <= hold_cnt_ff + 12'h001;
        end
    end

    assign timeout_evt = mbus_hold && (hold_cnt_ff == FCS_HOLD_CYCLES - 12'h001);

    // disengage the master until it lets go
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            disengage_ff <= 1'b0;
        end
        else if (timeout_evt)
        begin
            disengage_ff <= 1'b1;
        end
        else if (!mbus_hold)
        begin
            disengage_ff <= 1'b0;
        end
    end

    // parity faults only count when enabled
    assign parity_evt  = parity_err && cfg_ctrl_ff.parity_irq_enable;
    assign fault_evt   = timeout_evt || parity_evt;
    // pending register read releases the capture
    assign release_evt = reg_rd && (reg_addr == FCS_ADDR_PENDING);
    // a new fault beats a release in the same cycle
    assign capture     = fault_evt && (!held_ff || release_evt);

    // freeze on fault, raise level five irq
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            held_ff  <= 1'b0;
            irq_n_ff <= 1'b1;
        end
        else if (capture)
        begin
            held_ff  <= 1'b1;
            irq_n_ff <= 1'b0;
        end
        else if (release_evt)
        begin
            held_ff  <= 1'b0;
            irq_n_ff <= 1'b1;
        end
    end

    // address follows the memory controller while free
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            fault_addr_ff <= 32'h00000000;
        end
        else if (!held_ff || capture)
        begin
            fault_addr_ff <= mem_addr;
        end
    end

    // cause of the fault from the access attributes
    always_comb
    begin
        nxt_fault_log = '0;
        // per byte parity flags, ones when timed out
        nxt_fault_log.byte_parity_fail_n = timeout_evt ? 4'hf
                                         : ~{mem_attr.byte_parity_fail[0],
                                             mem_attr.byte_parity_fail[1],
                                             mem_attr.byte_parity_fail[2],
                                             mem_attr.byte_parity_fail[3]};
        nxt_fault_log.acc_type_n = ~mem_attr.acc_type;
        nxt_fault_log.fault_was_read = mem_attr.is_read;
        nxt_fault_log.timeout = timeout_evt;
        nxt_fault_log.rsvd = 3'h0;
        nxt_fault_log.processor_board_fault = mem_attr.proc_board;
        nxt_fault_log.io_master_code = mem_attr.io_master_code;
        // active low validity of the code
        nxt_fault_log.io_master_code_invalid_n = ~mem_attr.io_master_valid;
    end

    // log taken with the address, stable while held
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            fault_log_ff <= '0;
        end
        else if (capture)
        begin
            fault_log_ff <= nxt_fault_log;
        end
    end

    // only the control half is writable
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cfg_ctrl_ff <= fcs_cfg_ctrl_t'(FCS_CFG_CTRL_RST);
        end
        else if (reg_wr && (reg_addr == FCS_ADDR_SYS_CFG))
        begin
            cfg_ctrl_ff <= fcs_cfg_ctrl_t'(reg_wdata[FCS_CFG_CTRL_MSB:FCS_CFG_CTRL_LSB]);
        end
    end

    // wait states on a slow dma controller read
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            wait_cnt_ff <= 4'h0;
            wait_ff     <= 1'b0;
        end
        else if (dma_ctrl_read && cfg_ctrl_ff.slow_dma_read_enable && wait_cnt_ff == 4'h0)
        begin
            wait_cnt_ff <= SLOW_WAIT_CYCLES;
            wait_ff     <= (SLOW_WAIT_CYCLES != 4'h0);
        end
        else if (wait_cnt_ff != 4'h0)
        begin
            wait_cnt_ff <= wait_cnt_ff - 4'h1;
            wait_ff     <= (wait_cnt_ff > 4'h1);
        end
    end

    // configuration view, status in the low byte
    always_comb
    begin
        cfg_view = 16'h0000;
        cfg_view[FCS_CFG_CTRL_MSB:FCS_CFG_CTRL_LSB] = cfg_ctrl_ff;
        cfg_view[7] = pin_sync_ff[2];
        cfg_view[6:5] = 2'h0;
        cfg_view[4] = cold_start_ff;
        cfg_view[3] = pin_sync_ff[1];
        cfg_view[2:1] = scsi_byte_pointer;
        cfg_view[0] = pin_sync_ff[0];
    end

    // read decode, unmapped reads zero
    always_comb
    begin
        nxt_rdata = 32'h00000000;
        if (reg_rd)
        begin
            unique case (reg_addr)
                FCS_ADDR_SYS_CFG:   nxt_rdata = {16'h0000, cfg_view};
                FCS_ADDR_FAULT_ADR: nxt_rdata = fault_addr_ff;
                FCS_ADDR_FAULT_LOG: nxt_rdata = {16'h0000, fault_log_ff};
                default:            nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata_ff <= 32'h00000000;
        end
        else
        begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata        = reg_rdata_ff;
    assign master_disengage = disengage_ff;
    assign bus_error_irq_n  = irq_n_ff;
    assign dma_read_wait    = wait_ff;
    assign scsi_dma_init = cfg_ctrl_ff.scsi_dma_init;
    // direction to dma machine and protocol controller
    assign scsi_dir_to_memory = cfg_ctrl_ff.scsi_dir_to_memory;
    // end of process to the dma controller
    assign software_end_of_process = cfg_ctrl_ff.software_end_of_process;
    assign expansion_bus_reset_n = cfg_ctrl_ff.expansion_bus_reset_n;
    assign expansion_terminal_count_enable = cfg_ctrl_ff.expansion_terminal_count_enable;
    assign slow_dma_read_enable = cfg_ctrl_ff.slow_dma_read_enable;
    assign parity_fault_inject = cfg_ctrl_ff.parity_fault_inject;
    assign parity_irq_enable   = cfg_ctrl_ff.parity_irq_enable;

endmodule : fcs_fault_capture_and_system_config

/* File: sim/fcs_chk_assertions.sv */
`timescale 1ns/1ps
module fcs_chk
    import fcs_pkg::*;
#(
    parameter logic [3:0] SLOW_WAIT_CYCLES = FCS_SLOW_WAIT_RST
)
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        mbus_hold,
    input wire logic        parity_err,
    input wire logic        master_disengage,
    input wire logic        bus_error_irq_n,
    input wire logic        dma_ctrl_read,
    input wire logic        dma_read_wait,
    input wire logic        slow_dma_read_enable,
    input wire logic        expansion_bus_reset_n,
    input wire logic        parity_irq_enable
);
    logic [11:0] hold_cnt_ff;
    logic [3:0]  wait_len_ff;
    logic        rel_rd;
    assign rel_rd = reg_rd && reg_addr == FCS_ADDR_PENDING;
    // consecutive bus hold cycles
    always_ff @(posedge mclk or posedge reset)
        if (reset || !mbus_hold)
            hold_cnt_ff <= 12'h0;
        else if (hold_cnt_ff != 12'hfff)
            hold_cnt_ff <= hold_cnt_ff + 12'h1;
    // length of a wait state run
    always_ff @(posedge mclk or posedge reset)
        if (reset || !dma_read_wait)
            wait_len_ff <= 4'h0;
        else
            wait_len_ff <= wait_len_ff + 4'h1;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    timeout_fire_a:
    assert property (mbus_hold && hold_cnt_ff == FCS_HOLD_CYCLES - 12'h1
        |=> master_disengage && !bus_error_irq_n) else $error("no disengage at limit");
    timeout_early_a:
    assert property (mbus_hold && hold_cnt_ff < FCS_HOLD_CYCLES - 12'h1 && !master_disengage
        |=> !master_disengage) else $error("early disengage");
    disengage_drop_a:
    assert property (master_disengage && !mbus_hold |=> !master_disengage)
        else $error("disengage stuck");
    rsvd_zero_a:
    assert property (reg_rd && reg_addr == FCS_ADDR_FAULT_LOG |=> reg_rdata[10:8] == 3'h0)
        else $error("reserved log bits set");
    parity_irq_a:
    assert property (parity_err && parity_irq_enable |=> !bus_error_irq_n)
        else $error("parity fault without irq");
    parity_mask_a:
    assert property (parity_err && !parity_irq_enable && bus_error_irq_n && !mbus_hold
        |=> bus_error_irq_n) else $error("masked parity raised irq");
    irq_release_a:
    assert property (rel_rd && !parity_err && !mbus_hold |=> bus_error_irq_n)
        else $error("release read kept irq");
    irq_held_a:
    assert property (!bus_error_irq_n && !rel_rd |=> !bus_error_irq_n)
        else $error("irq dropped without release");
    cfg_write_a:
    assert property (reg_wr && reg_addr == FCS_ADDR_SYS_CFG |=>
        parity_irq_enable == $past(reg_wdata[15]) && expansion_bus_reset_n == $past(reg_wdata[11])
        && slow_dma_read_enable == $past(reg_wdata[13])) else $error("control write lost");
    rdata_idle_a:
    assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data without read");
    slow_start_a:
    assert property (dma_ctrl_read && slow_dma_read_enable && !dma_read_wait |=> dma_read_wait)
        else $error("slow read got no wait");
    slow_len_a:
    assert property ($fell(dma_read_wait) |-> wait_len_ff == SLOW_WAIT_CYCLES)
        else $error("wait run length wrong");
    cover property (!bus_error_irq_n ##1 bus_error_irq_n);
    cover property (master_disengage);
    cover property ($fell(dma_read_wait));
endmodule : fcs_chk

bind fcs_fault_capture_and_system_config fcs_chk #(
    .SLOW_WAIT_CYCLES(SLOW_WAIT_CYCLES)
) u_fcs_chk (.*);

/* File: sim/fcs_mem_model.sv */
`timescale 1ns/1ps
module fcs_mem_model
(
    input  wire logic   mclk,
    input  wire logic   reset,
    input  wire logic   par_req,
    input  wire logic   hold_req,
    input  wire logic   master_disengage,
    output logic [31:0] mem_addr,
    output logic        mbus_hold,
    output logic        parity_err
);
    // address walks every cycle
    always_ff @(posedge mclk or posedge reset)
        if (reset)
            mem_addr <= 32'h0010_0000;
        else
            mem_addr <= mem_addr + 32'h4;
    always_ff @(posedge mclk or posedge reset)
        if (reset || master_disengage)
            mbus_hold <= 1'b0;
        else if (hold_req)
            mbus_hold <= 1'b1;
    assign parity_err = par_req;
endmodule : fcs_mem_model

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import fcs_pkg::*;
;
    localparam logic [3:0] SLOW_W = 4'h3;
    logic            mclk = 1'b0;
    logic            reset = 1'b1;
    logic [31:0]     reg_addr = '0;
    logic [31:0]     reg_wdata = '0;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [31:0]     reg_rdata;
    logic [31:0]     mem_addr;
    fcs_fault_attr_t mem_attr = '0;
    logic            mbus_hold;
    logic            parity_err;
    logic            par_req = 1'b0;
    logic            hold_req = 1'b0;
    logic            master_disengage;
    logic            bus_error_irq_n;
    logic [3:0]      straps = 4'hc;
    logic [1:0]      ptr = 2'h1;
    logic            dma_ctrl_read = 1'b0;
    logic            dma_read_wait;
    logic [7:0]      ctrl;
    int              err_count = 0;
    int              n_checks = 0;
    always #2 mclk = ~mclk;
    fcs_mem_model u_fcs_mem_model (.mclk(mclk), .reset(reset), .par_req(par_req),
        .hold_req(hold_req), .master_disengage(master_disengage), .mem_addr(mem_addr),
        .mbus_hold(mbus_hold), .parity_err(parity_err));
    fcs_fault_capture_and_system_config #(.SLOW_WAIT_CYCLES(SLOW_W))
    u_fcs_fault_capture_and_system_config (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mem_addr(mem_addr), .mem_attr(mem_attr), .mbus_hold(mbus_hold),
        .parity_err(parity_err), .master_disengage(master_disengage),
        .bus_error_irq_n(bus_error_irq_n), .cpu_board_kind(straps[3]),
        .keyswitch_locked_n(straps[2]), .fpu_present_n(straps[1]),
        .keyswitch_reset_cause(straps[0]), .scsi_byte_pointer(ptr),
        .dma_ctrl_read(dma_ctrl_read), .dma_read_wait(dma_read_wait),
        .scsi_dma_init(ctrl[0]), .scsi_dir_to_memory(ctrl[1]),
        .software_end_of_process(ctrl[2]), .expansion_bus_reset_n(ctrl[3]),
        .expansion_terminal_count_enable(ctrl[4]), .slow_dma_read_enable(ctrl[5]),
        .parity_fault_inject(ctrl[6]), .parity_irq_enable(ctrl[7]));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(negedge mclk);
    endtask : bus_wr
    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : bus_rd
    task automatic do_reset;
        @(posedge mclk);
        reset <= 1'b1;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : do_reset
    task automatic pulse_par(input fcs_fault_attr_t attr, output logic [31:0] a);
        @(posedge mclk);
        par_req <= 1'b1;
        mem_attr <= attr;
        @(negedge mclk);
        a = mem_addr;
        @(posedge mclk);
        par_req <= 1'b0;
        @(negedge mclk);
    endtask : pulse_par
    task automatic t_cfg;
        logic [31:0] d;
        bus_rd(FCS_ADDR_SYS_CFG, d);
        chk(d, 32'h081b);
        chk({24'h0, ctrl}, 32'h08);
        bus_rd(32'h1800_0003, d);
        chk(d, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            bus_wr(FCS_ADDR_SYS_CFG, {16'h0, 8'h1 << i, 8'hff});
            chk({24'h0, ctrl}, {24'h0, 8'h1 << i});
            bus_rd(FCS_ADDR_SYS_CFG, d);
            chk(d, {16'h0, 8'h1 << i, 8'h1b});
        end
        @(posedge mclk);
        straps <= 4'h8;
        ptr <= 2'h0;
        repeat (4) @(posedge mclk);
        bus_rd(FCS_ADDR_SYS_CFG, d);
        chk(d[7:0], 8'h11);
        @(posedge mclk);
        straps <= 4'hd;
        ptr <= 2'h1;
        do_reset();
        bus_rd(FCS_ADDR_SYS_CFG, d);
        chk(d, 32'h080b);
        $display("config test done");
    endtask : t_cfg
    task automatic t_parity;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] d;
        bus_wr(FCS_ADDR_SYS_CFG, 32'h0800);
        pulse_par('0, a);
        chk(bus_error_irq_n, 1'b1);
        bus_wr(FCS_ADDR_SYS_CFG, 32'h8800);
        pulse_par({1'b1, 1'b1, 3'h5, 1'b1, 2'h2, 4'h1}, a);
        chk(bus_error_irq_n, 1'b0);
        pulse_par({1'b0, 1'b0, 3'h2, 1'b0, 2'h0, 4'h8}, b);
        bus_rd(FCS_ADDR_FAULT_LOG, d);
        chk(d, 32'h5857);
        bus_rd(FCS_ADDR_FAULT_ADR, d);
        chk(d, a);
        bus_rd(FCS_ADDR_PENDING, d);
        chk(bus_error_irq_n, 1'b1);
        pulse_par(mem_attr, b);
        bus_rd(FCS_ADDR_FAULT_LOG, d);
        chk(d, 32'ha03e);
        bus_rd(FCS_ADDR_FAULT_ADR, d);
        chk(d, b);
        bus_rd(FCS_ADDR_PENDING, d);
        $display("parity test done");
    endtask : t_parity
    task automatic t_timeout;
        logic [31:0] d;
        int          n;
        n = 0;
        @(posedge mclk);
        hold_req <= 1'b1;
        @(posedge mclk);
        hold_req <= 1'b0;
        while (master_disengage !== 1'b1 && n < 5000)
        begin
            @(negedge mclk);
            n++;
        end
        chk(n, 4001);
        bus_rd(FCS_ADDR_FAULT_LOG, d);
        chk(d[7:0] & 8'h8f, 8'h8f);
        chk(mbus_hold, 1'b0);
        bus_rd(FCS_ADDR_PENDING, d);
        $display("timeout test done");
    endtask : t_timeout
    task automatic t_slow(input logic [31:0] cfg, input int exp);
        int n;
        n = 0;
        bus_wr(FCS_ADDR_SYS_CFG, cfg);
        @(posedge mclk);
        dma_ctrl_read <= 1'b1;
        @(posedge mclk);
        dma_ctrl_read <= 1'b0;
        repeat (8) @(negedge mclk) n += int'(dma_read_wait);
        chk(n, exp);
        $display("slow read test done");
    endtask : t_slow
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial
    begin
        do_reset();
        t_cfg();
        t_parity();
        t_timeout();
        t_slow(32'h2800, int'(SLOW_W));
        t_slow(32'h0800, 0);
        tally_and_finish();
    end
endmodule : tb_top
